// File: design/abx_exec.sv
// The address-and-strobe port and the register offsets were decided locally.
`include "abx_defines.svh"

module abx_exec
  import abx_pkg::*;
#(
  parameter int PC_W = 16,
  parameter int STACK_DEPTH = 8
) (
  input wire logic CLK_I,
  input wire logic RST_I,
  input wire logic ISSUE_I,
  input wire abx_op_t OP_I,
  input wire logic [4:0] DEST_I,
  input wire logic [4:0] SRC_I,
  input wire logic [7:0] IMM_I,
  input wire logic [2:0] BIT_I,
  input wire logic [11:0] OFFSET_I,
  input wire logic NEXT_TWO_WORD_I,
  input wire logic [7:0] IO_BITS_I,
  input wire logic [5:0] ADDR_I,
  input wire logic [7:0] WDATA_I,
  input wire logic WE_I,
  input wire logic RE_I,
  output logic [7:0] RDATA_O,
  output logic READY_O,
  output logic TAKEN_O,
  output logic [PC_W-1:0] PC_O,
  output logic [7:0] FLAGS_O
);

  localparam int SP_W = $clog2(STACK_DEPTH);

  // ****************************************************************
  // State
  // ****************************************************************
  logic [7:0] regs_q [`ABX_NUM_REGS];
  logic [7:0] flags_q;
  logic [PC_W-1:0] pc_q;
  logic [SP_W-1:0] sp_q;
  abx_state_t state_q;
  logic [2:0] wait_q;
  logic return_q;
  logic irq_exit_q;
  logic taken_q;
  logic [7:0] rdata_q;

  abx_stack_if #(.W(PC_W), .AW(SP_W)) stk ();

  abx_store #(.W(PC_W), .DEPTH(STACK_DEPTH), .AW(SP_W)) u_stack (
    .clk_i(CLK_I),
    .port(stk.store)
  );

  // ****************************************************************
  // Operand fetch and decode
  // ****************************************************************
  // Working registers are flops, not the memory block: both operands
  // must be seen in the issue cycle for single-cycle execution.
  wire abx_op_t op = OP_I;
  wire accept = ISSUE_I && (state_q == ST_READY);
  wire [7:0] rd_v = regs_q[DEST_I];
  wire [7:0] src_v = regs_q[SRC_I];

  wire uses_imm = op inside {OP_DIFF_IMM, OP_DIFF_IMM_BORROW,
    OP_BITWISE_CONJ_IMM, OP_BITWISE_DISJ_IMM, OP_BITS_SET_BY_MASK,
    OP_BITS_CLEAR_BY_MASK, OP_COMPARE_IMM};
  wire with_carry = op inside {OP_ADD_CARRY, OP_DIFF_REGS_BORROW,
    OP_DIFF_IMM_BORROW, OP_COMPARE_REGS_BORROW};
  wire is_cmp = op inside {OP_COMPARE_REGS, OP_COMPARE_REGS_BORROW,
    OP_COMPARE_IMM};
  wire is_step = op inside {OP_INC, OP_MINUS_ONE};
  wire grp_add = op inside {OP_ADD, OP_ADD_CARRY, OP_INC};
  wire grp_sub = is_cmp || (op inside {OP_SUB, OP_DIFF_IMM,
    OP_DIFF_REGS_BORROW, OP_DIFF_IMM_BORROW, OP_TWOS_INVERT,
    OP_ONES_INVERT, OP_MINUS_ONE});
  wire grp_logic = op inside {OP_AND, OP_BITWISE_CONJ_IMM, OP_OR,
    OP_BITWISE_DISJ_IMM, OP_BITWISE_XOR, OP_BITS_SET_BY_MASK,
    OP_BITS_CLEAR_BY_MASK, OP_SELF_TEST_FLAGS, OP_ZERO_REGISTER};
  wire is_fill = (op == OP_ONES_FILL);
  wire is_jump = (op == OP_REL_JUMP);
  wire is_call = (op == OP_REL_SUBCALL);
  wire is_return = op inside {OP_SUB_EXIT, OP_IRQ_EXIT};
  wire is_skip = op inside {OP_EQUAL_SKIP, OP_SKIP_REG_BIT_LOW,
    OP_SKIP_REG_BIT_HIGH, OP_SKIP_IO_BIT_LOW, OP_SKIP_IO_BIT_HIGH};
  wire is_branch = op inside {OP_BRANCH_FLAG_HIGH, OP_BRANCH_FLAG_LOW,
    OP_BRANCH_SIGNED_GE, OP_BRANCH_SIGNED_LT, OP_BRANCH_UNSIGNED_GE,
    OP_BRANCH_UNSIGNED_LT};

  // ****************************************************************
  // Arithmetic unit
  // ****************************************************************
  wire [7:0] a_v = (op == OP_TWOS_INVERT) ? 8'h00 :
                   (op == OP_ONES_INVERT) ? `ABX_ALL_ONES : rd_v;
  wire [7:0] b_v = is_step ? 8'h01 :
                   uses_imm ? IMM_I :
                   (op inside {OP_TWOS_INVERT, OP_ONES_INVERT}) ? rd_v :
                   src_v;
  wire cin = with_carry & flags_q[`ABX_FLG_WRAP];
  wire [8:0] sum9 = {1'b0, a_v} + {1'b0, b_v} + {8'h00, cin};
  wire [8:0] dif9 = {1'b0, a_v} - {1'b0, b_v} - {8'h00, cin};

  logic [7:0] logic_v;
  always_comb begin
    case (op)
      OP_AND, OP_BITWISE_CONJ_IMM: logic_v = rd_v & b_v;
      OP_OR, OP_BITWISE_DISJ_IMM: logic_v = rd_v | b_v;
      OP_BITS_SET_BY_MASK: logic_v = rd_v | IMM_I;
      OP_BITS_CLEAR_BY_MASK: begin
        logic_v = rd_v & (`ABX_ALL_ONES ^ IMM_I);
      end
      OP_BITWISE_XOR: logic_v = rd_v ^ src_v;
      OP_ZERO_REGISTER: logic_v = rd_v ^ rd_v;
      OP_SELF_TEST_FLAGS: logic_v = rd_v & rd_v;
      default: logic_v = `ABX_ALL_ONES;
    endcase
  end

  wire [7:0] res_v = grp_add ? sum9[7:0] :
                     grp_sub ? dif9[7:0] : logic_v;
  // Compares run the subtractor but never write back.
  wire alu_wr = (grp_add || grp_sub || grp_logic || is_fill) &&
                !is_cmp;

  wire a3 = a_v[3];
  wire b3 = b_v[3];
  wire r3 = res_v[3];
  wire a7 = a_v[7];
  wire b7 = b_v[7];
  wire r7 = res_v[7];
  wire h_add = (a3 & b3) | (b3 & ~r3) | (~r3 & a3);
  wire v_add = (a7 & b7 & ~r7) | (~a7 & ~b7 & r7);
  wire h_sub = (~a3 & b3) | (b3 & r3) | (r3 & ~a3);
  wire v_sub = (a7 & ~b7 & ~r7) | (~a7 & b7 & r7);

  // Which flags an operation owns; every other flag keeps its value.
  wire m_znv = grp_add || grp_sub || grp_logic;
  wire m_c = (grp_add || grp_sub) && !is_step;
  wire m_h = m_c && (op != OP_ONES_INVERT);

  logic [7:0] fmask;
  logic [7:0] fnew;
  always_comb begin
    fmask = 8'h00;
    fmask[`ABX_FLG_NIL] = m_znv;
    fmask[`ABX_FLG_MSB] = m_znv;
    fmask[`ABX_FLG_SWRAP] = m_znv;
    fmask[`ABX_FLG_WRAP] = m_c;
    fmask[`ABX_FLG_NIBBLE] = m_h;
    fnew = 8'h00;
    fnew[`ABX_FLG_NIL] = (res_v == 8'h00);
    fnew[`ABX_FLG_MSB] = r7;
    fnew[`ABX_FLG_SWRAP] = grp_add ? v_add : (grp_sub ? v_sub : 1'b0);
    fnew[`ABX_FLG_WRAP] = grp_add ? sum9[8] : dif9[8];
    fnew[`ABX_FLG_NIBBLE] = grp_add ? h_add : h_sub;
  end

  wire [7:0] flags_alu = (flags_q & ~fmask) | (fnew & fmask);

  // ****************************************************************
  // Flow decisions
  // ****************************************************************
  // Named branches (equal, carry, minus, half carry, overflow,
  // interrupt state, copy flag) are flag branches with BIT_I set.
  wire flag_sel =
                  flags_q[BIT_I];
  wire nxv = flags_q[`ABX_FLG_MSB] ^ flags_q[`ABX_FLG_SWRAP];
  wire cflag = flags_q[`ABX_FLG_WRAP];

  logic cond;
  always_comb begin
    case (op)
      OP_BRANCH_FLAG_HIGH: cond = flag_sel;
      OP_BRANCH_FLAG_LOW: cond = ~flag_sel;
      OP_BRANCH_SIGNED_GE: cond = ~nxv;
      OP_BRANCH_SIGNED_LT: cond = nxv;
      OP_BRANCH_UNSIGNED_GE: cond = ~cflag;
      OP_BRANCH_UNSIGNED_LT: cond = cflag;
      OP_EQUAL_SKIP: cond = (rd_v == src_v);
      OP_SKIP_REG_BIT_LOW: cond = ~src_v[BIT_I];
      OP_SKIP_REG_BIT_HIGH: cond = src_v[BIT_I];
      OP_SKIP_IO_BIT_LOW: cond = ~IO_BITS_I[BIT_I];
      OP_SKIP_IO_BIT_HIGH: cond = IO_BITS_I[BIT_I];
      default: cond = 1'b0;
    endcase
  end

  wire br_taken = is_branch && cond;
  wire sk_taken = is_skip && cond;
  wire [PC_W-1:0] pc_inc = pc_q + PC_W'(1);
  wire [PC_W-1:0] off_x = PC_W'({{(PC_W - 12){OFFSET_I[11]}}, OFFSET_I});
  wire [PC_W-1:0] pc_rel = pc_inc + off_x;
  wire [PC_W-1:0] pc_skip = pc_q + (NEXT_TWO_WORD_I ? PC_W'(3)
                                                      : PC_W'(2));

  wire [PC_W-1:0] pc_next = (is_jump || is_call || br_taken) ? pc_rel :
                            sk_taken ? pc_skip :
                            is_return ? pc_q : pc_inc;

  wire [2:0] cycles = is_jump ? `ABX_CYC_JUMP :
                      is_call ? `ABX_CYC_CALL :
                      is_return ? `ABX_CYC_RETURN :
                      (br_taken || sk_taken) ? `ABX_CYC_TAKEN :
                      `ABX_CYC_BASE;

  wire return_done = (state_q == ST_STALL) && (wait_q == 3'h1) && return_q;

  assign stk.wr_en = accept && is_call;
  assign stk.wr_addr = sp_q;
  assign stk.wr_data = pc_inc;
  assign stk.rd_addr = sp_q - SP_W'(1);

  // ****************************************************************
  // Register port decode
  // ****************************************************************
  wire bus_reg_we = WE_I && (ADDR_I <= `ABX_OFS_REGS_TOP);
  wire bus_flg_we = WE_I && (ADDR_I == `ABX_OFS_FLAGS);
  wire bus_pcl_we = WE_I && (ADDR_I == `ABX_OFS_PC_LO);
  wire bus_pch_we = WE_I && (ADDR_I == `ABX_OFS_PC_HI);
  wire [7:0] status_v = {6'h00, taken_q, state_q == ST_READY};
  wire [7:0] read_v = (ADDR_I <= `ABX_OFS_REGS_TOP) ? regs_q[ADDR_I[4:0]] :
                      (ADDR_I == `ABX_OFS_FLAGS) ? flags_q :
                      (ADDR_I == `ABX_OFS_PC_LO) ? pc_q[7:0] :
                      (ADDR_I == `ABX_OFS_PC_HI) ? 8'(pc_q >> 8) :
                      (ADDR_I == `ABX_OFS_STATUS) ? status_v : 8'h00;

  // ****************************************************************
  // Working registers
  // ****************************************************************
  // Execution writes after the port write, so it wins on a clash.
  always_ff @(posedge CLK_I) begin
    if (RST_I) begin
      for (int i = 0; i < `ABX_NUM_REGS; i++) begin
        regs_q[i] <= `ABX_REG_RST;
      end
    end else begin
      if (bus_reg_we) begin
        regs_q[ADDR_I[4:0]] <= WDATA_I;
      end
      if (accept && alu_wr) begin
        regs_q[DEST_I] <= res_v;
      end
    end
  end

  // ****************************************************************
  // Flags, program counter and stack
  // ****************************************************************
  always_ff @(posedge CLK_I) begin
    if (RST_I) begin
      flags_q <= `ABX_FLAGS_RST;
    end else if (accept && m_znv) begin
      flags_q <= flags_alu;
    end else if (return_done && irq_exit_q) begin
      flags_q[`ABX_FLG_MASTER] <= 1'b1;
    end else if (bus_flg_we) begin
      flags_q <= WDATA_I;
    end
  end

  always_ff @(posedge CLK_I) begin
    if (RST_I) begin
      pc_q <= '0;
    end else if (accept) begin
      pc_q <= pc_next;
    end else if (return_done) begin
      pc_q <= stk.rd_data;
    end else if (bus_pcl_we) begin
      pc_q <= {pc_q[PC_W-1:8], WDATA_I};
    end else if (bus_pch_we) begin
      pc_q <= PC_W'({WDATA_I, pc_q[7:0]});
    end
  end

  // The stack wraps silently; software must not nest past its depth.
  always_ff @(posedge CLK_I) begin
    if (RST_I) begin
      sp_q <= '0;
    end else if (accept && is_call) begin
      sp_q <= sp_q + SP_W'(1);
    end else if (return_done) begin
      sp_q <= sp_q - SP_W'(1);
    end
  end

  // ****************************************************************
  // Sequencer
  // ****************************************************************
  always_ff @(posedge CLK_I) begin
    if (RST_I) begin
      state_q <= ST_READY;
      wait_q <= 3'h0;
      return_q <= 1'b0;
      irq_exit_q <= 1'b0;
    end else begin
      case (state_q)
        ST_READY: begin
          if (accept && (cycles != `ABX_CYC_BASE)) begin
            state_q <= ST_STALL;
            wait_q <= cycles - 3'h1;
            return_q <= is_return;
            irq_exit_q <= (op == OP_IRQ_EXIT);
          end
        end
        ST_STALL: begin
          wait_q <= wait_q - 3'h1;
          if (wait_q == 3'h1) begin
            state_q <= ST_READY;
            return_q <= 1'b0;
            irq_exit_q <= 1'b0;
          end
        end
        default: begin
          state_q <= ST_READY;
        end
      endcase
    end
  end

  always_ff @(posedge CLK_I) begin
    if (RST_I) begin
      taken_q <= 1'b0;
      rdata_q <= 8'h00;
    end else begin
      if (accept) begin
        taken_q <= br_taken || sk_taken || is_jump || is_call || is_return;
      end
      rdata_q <= RE_I ? read_v : 8'h00;
    end
  end

  assign RDATA_O = rdata_q;
  assign READY_O = state_q[0];
  assign TAKEN_O = taken_q;
  assign PC_O = pc_q;
  assign FLAGS_O = flags_q;

endmodule

// File: design/abx_defines.svh
`ifndef ABX_DEFINES_SVH
`define ABX_DEFINES_SVH

// ****************************************************************
// Condition flag bit positions
// ****************************************************************
`define ABX_FLG_WRAP 0
`define ABX_FLG_NIL 1
`define ABX_FLG_MSB 2
`define ABX_FLG_SWRAP 3
`define ABX_FLG_SIGN 4
`define ABX_FLG_NIBBLE 5
`define ABX_FLG_COPY 6
`define ABX_FLG_MASTER 7

// ****************************************************************
// Register port offsets
// ****************************************************************
`define ABX_OFS_REGS_TOP 6'h1F
`define ABX_OFS_FLAGS 6'h20
`define ABX_OFS_PC_LO 6'h21
`define ABX_OFS_PC_HI 6'h22
`define ABX_OFS_STATUS 6'h23

// ****************************************************************
// Reset values and fixed data
// ****************************************************************
`define ABX_FLAGS_RST 8'h00
`define ABX_REG_RST 8'h00
`define ABX_ALL_ONES 8'hFF
`define ABX_NUM_REGS 32

// ****************************************************************
// Execution cycle counts
// ****************************************************************
`define ABX_CYC_BASE 3'h1
`define ABX_CYC_TAKEN 3'h2
`define ABX_CYC_JUMP 3'h2
`define ABX_CYC_CALL 3'h3
`define ABX_CYC_RETURN 3'h4

`endif

// File: design/abx_pkg.sv
package abx_pkg;

  typedef enum logic [5:0] {
    OP_NOP = 6'h00,
    OP_ADD = 6'h01,
    OP_ADD_CARRY = 6'h02,
    OP_SUB = 6'h03,
    OP_DIFF_IMM = 6'h04,
    OP_DIFF_REGS_BORROW = 6'h05,
    OP_DIFF_IMM_BORROW = 6'h06,
    OP_AND = 6'h07,
    OP_BITWISE_CONJ_IMM = 6'h08,
    OP_OR = 6'h09,
    OP_BITWISE_DISJ_IMM = 6'h0A,
    OP_BITWISE_XOR = 6'h0B,
    OP_ONES_INVERT = 6'h0C,
    OP_TWOS_INVERT = 6'h0D,
    OP_BITS_SET_BY_MASK = 6'h0E,
    OP_BITS_CLEAR_BY_MASK = 6'h0F,
    OP_INC = 6'h10,
    OP_MINUS_ONE = 6'h11,
    OP_SELF_TEST_FLAGS = 6'h12,
    OP_ZERO_REGISTER = 6'h13,
    OP_ONES_FILL = 6'h14,
    OP_REL_JUMP = 6'h15,
    OP_REL_SUBCALL = 6'h16,
    OP_SUB_EXIT = 6'h17,
    OP_IRQ_EXIT = 6'h18,
    OP_EQUAL_SKIP = 6'h19,
    OP_COMPARE_REGS = 6'h1A,
    OP_COMPARE_REGS_BORROW = 6'h1B,
    OP_COMPARE_IMM = 6'h1C,
    OP_SKIP_REG_BIT_LOW = 6'h1D,
    OP_SKIP_REG_BIT_HIGH = 6'h1E,
    OP_SKIP_IO_BIT_LOW = 6'h1F,
    OP_SKIP_IO_BIT_HIGH = 6'h20,
    OP_BRANCH_FLAG_HIGH = 6'h21,
    OP_BRANCH_FLAG_LOW = 6'h22,
    OP_BRANCH_SIGNED_GE = 6'h23,
    OP_BRANCH_SIGNED_LT = 6'h24,
    OP_BRANCH_UNSIGNED_GE = 6'h25,
    OP_BRANCH_UNSIGNED_LT = 6'h26
  } abx_op_t;

  typedef enum logic [1:0] {
    ST_READY = 2'b01,
    ST_STALL = 2'b10
  } abx_state_t;

endpackage

// File: design/abx_stack_if.sv
interface abx_stack_if #(
  parameter int W = 16,
  parameter int AW = 3
);
  logic wr_en;
  logic [AW-1:0] wr_addr;
  logic [W-1:0] wr_data;
  logic [AW-1:0] rd_addr;
  logic [W-1:0] rd_data;

  modport store (
    input wr_en,
    input wr_addr,
    input wr_data,
    input rd_addr,
    output rd_data
  );

  modport user (
    output wr_en,
    output wr_addr,
    output wr_data,
    output rd_addr,
    input rd_data
  );
endinterface

// File: design/abx_store.sv
module abx_store #(
  parameter int W = 16,
  parameter int DEPTH = 8,
  parameter int AW = 3
) (
  input wire logic clk_i,
  abx_stack_if.store port
);

  logic [W-1:0] mem [DEPTH];
  logic [W-1:0] rd_q;

  // Read data always come from a register; the caller keeps the
  // address stable for a cycle before it uses the word.
  always_ff @(posedge clk_i) begin
    if (port.wr_en) begin
      mem[port.wr_addr] <= port.wr_data;
    end
    rd_q <= mem[port.rd_addr];
  end

  assign port.rd_data = rd_q;

endmodule

// File: sim/abx_exec_properties.sv
module abx_exec_properties
  import abx_pkg::*;
#(
  parameter int PC_W = 16
) (
  input wire logic CLK_I,
  input wire logic RST_I,
  input wire logic ISSUE_I,
  input wire abx_op_t OP_I,
  input wire logic [2:0] BIT_I,
  input wire logic [11:0] OFFSET_I,
  input wire logic [7:0] IO_BITS_I,
  input wire logic WE_I,
  input wire logic RE_I,
  input wire logic [7:0] RDATA_O,
  input wire logic READY_O,
  input wire logic TAKEN_O,
  input wire logic [PC_W-1:0] PC_O,
  input wire logic [7:0] FLAGS_O
);
  default clocking cb @(posedge CLK_I); endclocking
  default disable iff (RST_I);
  logic acc;
  logic io_hit;
  logic lt_cond;
  logic [PC_W-1:0] off_ext;
  assign acc = ISSUE_I && READY_O;
  assign io_hit = IO_BITS_I[BIT_I];
  assign lt_cond = FLAGS_O[2] ^ FLAGS_O[3];
  assign off_ext = PC_W'($signed(OFFSET_I));

  rd_slot_a:
    assert property (RDATA_O != 8'h00 |-> $past(RE_I))
    else $error("read data outside its slot");
  alu_one_a:
    assert property (acc && OP_I inside {OP_ADD, OP_ADD_CARRY, OP_SUB,
      OP_COMPARE_REGS} |=> READY_O && !TAKEN_O)
    else $error("alu op not single cycle");
  // A bus flag write in the same edge loses to the flag update; the check skips it anyway.
  logic_keeps_a:
    assert property (acc && !WE_I && OP_I inside {OP_AND, OP_OR,
      OP_BITWISE_XOR} |=> (FLAGS_O & 8'h21) == ($past(FLAGS_O) & 8'h21))
    else $error("logic op changed carry or half carry");
  jump_two_a:
    assert property (acc && !WE_I && OP_I == OP_REL_JUMP |=> !READY_O &&
      TAKEN_O && PC_O == PC_W'($past(PC_O) + $past(off_ext) + 1) ##1 READY_O)
    else $error("relative jump target or timing wrong");
  call_three_a:
    assert property (acc && OP_I == OP_REL_SUBCALL |=>
      !READY_O [*2] ##1 READY_O)
    else $error("call not three cycles");
  return_four_a:
    assert property (acc && OP_I inside {OP_SUB_EXIT, OP_IRQ_EXIT} |=>
      !READY_O [*3] ##1 READY_O)
    else $error("return not four cycles");
  irq_master_a:
    assert property (acc && OP_I == OP_IRQ_EXIT |-> ##4 FLAGS_O[7])
    else $error("interrupt return left master enable clear");
  io_skip_a:
    assert property (acc && OP_I == OP_SKIP_IO_BIT_HIGH |=>
      READY_O == !$past(io_hit) && TAKEN_O == $past(io_hit))
    else $error("io bit skip decision wrong");
  lt_branch_a:
    assert property (acc && !WE_I && OP_I == OP_BRANCH_SIGNED_LT |=>
      PC_O == PC_W'($past(PC_O) + ($past(lt_cond) ? $past(off_ext) + 1 : 1)))
    else $error("signed less branch target wrong");

  cover property (acc && OP_I == OP_REL_SUBCALL);
  cover property (acc && OP_I == OP_IRQ_EXIT);
  cover property (acc && OP_I == OP_EQUAL_SKIP);
endmodule

bind abx_exec abx_exec_properties #(.PC_W(PC_W)) u_props (.CLK_I, .RST_I,
  .ISSUE_I, .OP_I, .BIT_I, .OFFSET_I, .IO_BITS_I, .WE_I, .RE_I, .RDATA_O,
  .READY_O, .TAKEN_O, .PC_O, .FLAGS_O);

// File: sim/abx_exec_tb.sv
`include "abx_defines.svh"

module abx_exec_tb
  import abx_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic CLK_I = 0, RST_I = 1, ISSUE_I = 0, NEXT_TWO_WORD_I = 0;
  logic WE_I = 0, RE_I = 0, READY_O, TAKEN_O;
  abx_op_t OP_I = OP_NOP;
  logic [4:0] DEST_I = 5'h01, SRC_I = 5'h02;
  logic [7:0] IMM_I = 8'h00, IO_BITS_I = 8'h00, WDATA_I = 8'h00;
  logic [7:0] RDATA_O, FLAGS_O;
  logic [2:0] BIT_I = 3'h0;
  logic [11:0] OFFSET_I = 12'h000;
  logic [5:0] ADDR_I = 6'h00;
  logic [15:0] PC_O;
  int fail_count = 0, n_checks = 0;

  always #10 CLK_I = ~CLK_I;

  abx_exec #(.PC_W(16), .STACK_DEPTH(8)) DUT (.CLK_I, .RST_I, .ISSUE_I,
    .OP_I, .DEST_I, .SRC_I, .IMM_I, .BIT_I, .OFFSET_I, .NEXT_TWO_WORD_I,
    .IO_BITS_I, .ADDR_I, .WDATA_I, .WE_I, .RE_I, .RDATA_O, .READY_O,
    .TAKEN_O, .PC_O, .FLAGS_O);

  task automatic final_report();
    $display("checks %0d mismatches %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    n_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // Bounded so that a stuck stall ends the run instead of hanging it.
  task automatic wait_ready();
    int n;
    n = 0;
    #1;
    while (READY_O !== 1'b1) begin
      n++;
      if (n > 20) begin
        fail_count++;
        $display("mismatch at %0t: ready %h expected %h", $time, READY_O,
          1'b1);
        final_report();
      end
      @(posedge CLK_I);
      #1;
    end
  endtask

  task automatic wr(input logic [5:0] a, input logic [7:0] d);
    @(posedge CLK_I);
    ADDR_I <= a;
    WDATA_I <= d;
    WE_I <= 1'b1;
    @(posedge CLK_I);
    WE_I <= 1'b0;
  endtask

  task automatic rd(input logic [5:0] a, input logic [7:0] e);
    @(posedge CLK_I);
    ADDR_I <= a;
    RE_I <= 1'b1;
    @(posedge CLK_I);
    RE_I <= 1'b0;
    #1 check(RDATA_O, e);
    @(posedge CLK_I);
    #1 check(RDATA_O, 8'h00);
  endtask

  task automatic issue(input abx_op_t op, input logic [7:0] imm,
                       input logic [2:0] b, input logic [11:0] off);
    wait_ready();
    @(posedge CLK_I);
    OP_I <= op;
    IMM_I <= imm;
    BIT_I <= b;
    OFFSET_I <= off;
    ISSUE_I <= 1'b1;
    @(posedge CLK_I);
    ISSUE_I <= 1'b0;
    #1;
  endtask

  task automatic set_pc(input logic [15:0] p);
    wr(`ABX_OFS_PC_LO, p[7:0]);
    wr(`ABX_OFS_PC_HI, p[15:8]);
  endtask

  task automatic t_reset();
    #1 check(PC_O, 16'h0000);
    check(FLAGS_O, 8'h00);
    rd(6'h05, 8'h00);
    rd(`ABX_OFS_STATUS, 8'h01);
    wr(6'h30, 8'h5A);
    rd(6'h30, 8'h00);
    $display("test reset done");
  endtask

  // Row: first operand, second operand or immediate, flags in, result,
  // flags out, mask of flags the row is sure of.
  task automatic t_alu();
    abx_op_t op[23] = '{OP_ADD, OP_ADD_CARRY, OP_SUB, OP_DIFF_IMM_BORROW,
      OP_DIFF_IMM, OP_DIFF_REGS_BORROW, OP_AND, OP_OR, OP_BITWISE_XOR,
      OP_BITS_SET_BY_MASK, OP_BITS_CLEAR_BY_MASK, OP_BITWISE_CONJ_IMM,
      OP_BITWISE_DISJ_IMM, OP_ONES_INVERT, OP_TWOS_INVERT, OP_INC,
      OP_MINUS_ONE, OP_SELF_TEST_FLAGS, OP_ZERO_REGISTER, OP_ONES_FILL,
      OP_COMPARE_REGS, OP_COMPARE_REGS_BORROW, OP_COMPARE_IMM};
    logic [47:0] tv[23] = '{48'h0F0100_1020FF, 48'h7F0001_802CFF,
      48'h102000_F005FF, 48'h000001_FF25FF, 48'h100100_0F20FF,
      48'h010001_0002FF, 48'hC30F21_0321FF, 48'hC30F21_CF25FF,
      48'hC30F21_CC25FF, 48'hC30F21_CF25FF, 48'hC30F21_C025FF,
      48'hC30F21_0321FF, 48'hC30F21_CF25FF, 48'hC30F21_3C000E,
      48'hC30F21_3D000E, 48'hC30F21_C425FF, 48'hC30F21_C225FF,
      48'hC30F21_C325FF, 48'hC30F21_0023FF, 48'hC30F21_FF21FF,
      48'h101000_1002FF, 48'h100F01_1022FF, 48'h050600_0525FF};
    logic [47:0] v;
    // Compare rows expect the first operand back, as nothing is written.
    for (int i = 0; i < 23; i++) begin
      v = tv[i];
      wr(6'h01, v[47:40]);
      wr(6'h02, v[39:32]);
      wr(`ABX_OFS_FLAGS, v[31:24]);
      issue(op[i], v[39:32], 3'h0, 12'h000);
      check(FLAGS_O & v[7:0], v[15:8]);
      rd(6'h01, v[23:16]);
    end
    $display("test alu done");
  endtask

  // Row: flag index, flags preset, taken.
  task automatic t_branch();
    abx_op_t op[13] = '{OP_BRANCH_FLAG_HIGH, OP_BRANCH_FLAG_LOW,
      OP_BRANCH_FLAG_HIGH, OP_BRANCH_FLAG_LOW, OP_BRANCH_FLAG_HIGH,
      OP_BRANCH_FLAG_LOW, OP_BRANCH_FLAG_HIGH, OP_BRANCH_SIGNED_GE,
      OP_BRANCH_SIGNED_LT, OP_BRANCH_SIGNED_LT, OP_BRANCH_UNSIGNED_GE,
      OP_BRANCH_UNSIGNED_LT, OP_REL_JUMP};
    logic [15:0] bv[13] = '{16'h1021, 16'h0010, 16'h5201, 16'h3001,
      16'h7000, 16'h6400, 16'h2041, 16'h00C1, 16'h0041, 16'h00C0,
      16'h0010, 16'h0011, 16'h0001};
    for (int i = 0; i < 13; i++) begin
      wr(`ABX_OFS_FLAGS, bv[i][11:4]);
      set_pc(16'h0100);
      issue(op[i], 8'h00, bv[i][14:12], 12'hFFD);
      check(TAKEN_O, bv[i][0]);
      check(PC_O, bv[i][0] ? 16'h00FE : 16'h0101);
      check(FLAGS_O, bv[i][11:4]);
    end
    $display("test branch done");
  endtask

  task automatic t_skip();
    abx_op_t op[6] = '{OP_SKIP_REG_BIT_LOW, OP_SKIP_REG_BIT_HIGH,
      OP_SKIP_IO_BIT_HIGH, OP_SKIP_IO_BIT_LOW, OP_EQUAL_SKIP, OP_EQUAL_SKIP};
    logic [5:0] tk = 6'b110101;
    wr(6'h01, 8'h0F);
    wr(6'h02, 8'h0F);
    wr(`ABX_OFS_FLAGS, 8'h2A);
    IO_BITS_I <= 8'h10;
    for (int i = 0; i < 6; i++) begin
      set_pc(16'h0040);
      NEXT_TWO_WORD_I <= (i == 5);
      issue(op[i], 8'h00, 3'h4, 12'h000);
      check(TAKEN_O, tk[i]);
      check(PC_O, tk[i] ? 16'h0042 + 16'(i == 5) : 16'h0041);
      check(FLAGS_O, 8'h2A);
    end
    @(posedge CLK_I);
    NEXT_TWO_WORD_I <= 1'b0;
    $display("test skip done");
  endtask

  task automatic t_callret();
    wr(`ABX_OFS_FLAGS, 8'h00);
    set_pc(16'h0010);
    for (int i = 0; i < 2; i++) begin
      issue(OP_REL_SUBCALL, 8'h00, 3'h0, 12'h005);
      check(PC_O, 16'h0016 + 16'(i));
      issue(i ? OP_IRQ_EXIT : OP_SUB_EXIT, 8'h00, 3'h0, 12'h000);
      check(TAKEN_O, 1'b1);
      wait_ready();
      check(PC_O, 16'h0011 + 16'(i));
      check(FLAGS_O, i ? 8'h80 : 8'h00);
    end
    $display("test call return done");
  endtask

  initial begin
    repeat (4) @(posedge CLK_I);
    RST_I <= 1'b0;
    t_reset();
    t_alu();
    t_branch();
    t_skip();
    t_callret();
    final_report();
  end
endmodule
